/* File: csoc_params.svh */
// csoc_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package; the design file of the same block uses its macros
`ifndef CSOC_PARAMS_SVH
`define CSOC_PARAMS_SVH

`define CSOC_ADDR_W 8
`define CSOC_DATA_W 16

// register offsets
`define CSOC_OFS_CFG 8'h1d
`define CSOC_OFS_CFG_EXT 8'h1e
`define CSOC_OFS_OTP 8'h1f
`define CSOC_OFS_STATUS 8'h20

// reset values
`define CSOC_RST_CFG 16'h0028
`define CSOC_RST_CFG_EXT 16'h0833
`define CSOC_RST_OTP 16'h0000

// sense_amp_config fields
`define CSOC_GAIN_LSB 0
`define CSOC_GAIN_MSB 2
`define CSOC_GAINPIN_BIT 3
`define CSOC_AMPEN_LSB 4
`define CSOC_AMPEN_MSB 6
`define CSOC_BLANK_LSB 7
`define CSOC_BLANK_MSB 10
`define CSOC_DCCAL_BIT 11
`define CSOC_DEGL_LSB 12
`define CSOC_DEGL_MSB 13
`define CSOC_TRIG_LSB 14
`define CSOC_TRIG_MSB 15

// sense_amp_config_ext fields
`define CSOC_PTHR_LSB 0
`define CSOC_PTHR_MSB 3
`define CSOC_NTHR_LSB 4
`define CSOC_NTHR_MSB 7
`define CSOC_LATCH_BIT 8
`define CSOC_MODE_BIT 9
`define CSOC_BRAKE_BIT 10
`define CSOC_TRUNCDIS_BIT 11
`define CSOC_REFSEL_BIT 12
`define CSOC_NEGDIS_BIT 13
`define CSOC_AZ_LSB 14
`define CSOC_AZ_MSB 15

// otp_program_control fields
`define CSOC_OTPGO_BIT 0
`define CSOC_UID_LSB 1
`define CSOC_UID_MSB 4

// status register fields
`define CSOC_STAT_FAULT_BIT 0
`define CSOC_STAT_CLR_BIT 0

// timing
`define CSOC_CLK_PERIOD_NS 25
`define CSOC_DEGL_US_1 2
`define CSOC_DEGL_US_2 4
`define CSOC_DEGL_US_3 8
`define CSOC_TIME_W 9
`define CSOC_COUNT_8 5'd8
`define CSOC_COUNT_16 5'd16
`define CSOC_COUNT_1 5'd1

`endif

/* File: csoc_pkg.sv */
// csoc_pkg.sv: types of the current sense and over-current config block
// assumes: csoc_params.svh is on the include path
`default_nettype none

package csoc_pkg;
  `include "csoc_params.svh"

  typedef enum logic [1:0] {
    CSOC_TRIG_COUNT8 = 2'b00,
    CSOC_TRIG_COUNT16 = 2'b01,
    CSOC_TRIG_EVERY = 2'b10,
    CSOC_TRIG_NONE = 2'b11
  } csoc_trig_t;

  typedef enum logic [1:0] {
    CSOC_AZ_INT_SYNC = 2'b00,
    CSOC_AZ_OFF = 2'b01,
    CSOC_AZ_EXT_SYNC = 2'b10,
    CSOC_AZ_EXT_CPGATE = 2'b11
  } csoc_az_t;
endpackage

`default_nettype wire

/* File: csoc_config.sv */
// csoc_config.sv: register bank and over-current control for three sense amps
// assumes: one clock, comparator inputs synchronous to core_clk, host port
// with read data one cycle after the read strobe
//
// What this block does
// - gain comes from the gain field when pin select is 0, else the pin
// - gain codes 000..111 give 4,8,12,16,20,24,32,64 V/V
// - bits 6:4 enable amplifiers A, B, C individually, 1 enables
// - four-bit blanking code selects 0 ns up to 8 us
// - calibrate bit set runs DC calibration with power stages high-Z
// - deglitch 0/2/4/8 us, bypassed when truncation disable is 0
// - positive threshold code maps 300mV down to 20mV
// - negative threshold uses same coding, negative
// - latch bit: fault unlatched at 0, latched at 1
// - sensing mode 1 selects on-resistance and low-gate-on sampling only
// - brake bit makes fault brake and latch
// - truncation disable stops PWM truncation and applies the deglitch time to fault triggering
// - reference select: internal at 0, external pin at 1
// - negative disable suppresses negative truncation and fault
// - auto-zero field picks internal, off, external, external with gating
// - writing 1 to program bit starts OTP programming
// - four-bit user tag is read/write and goes to the OTP
// - program register upper bits read as zero
`default_nettype none

module csoc_config
  import csoc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  input wire logic [2:0] ocpPosHit,
  input wire logic [2:0] ocpNegHit,
  output logic [2:0] ampEnable,
  output logic gainFromPin,
  output logic [2:0] gainCode,
  output logic [6:0] gainVv,
  output logic [8:0] blankCycles,
  output logic dcCalActive,
  output logic powerStageHiZ,
  output logic [3:0] posThresholdCode,
  output logic [9:0] posThresholdMv,
  output logic [3:0] negThresholdCode,
  output logic [9:0] negThresholdMagMv,
  output logic rdsonSensing,
  output logic sampleLowGateOnly,
  output logic refExternal,
  output logic [1:0] autozeroMode,
  output logic [2:0] pwmTruncate,
  output logic ocpFault,
  output logic brakeRequest,
  output logic otpProgramStart,
  output logic [3:0] userVersionTag
);

  // ==========================================================
  // decode helpers
  // ==========================================================
  function automatic logic [6:0] gainOf(input logic [2:0] c);
    case (c)
      3'h0: gainOf = 7'd4;
      3'h1: gainOf = 7'd8;
      3'h2: gainOf = 7'd12;
      3'h3: gainOf = 7'd16;
      3'h4: gainOf = 7'd20;
      3'h5: gainOf = 7'd24;
      3'h6: gainOf = 7'd32;
      default: gainOf = 7'd64;
    endcase
  endfunction

  // threshold magnitude in mV, shared by both polarities
  function automatic logic [9:0] thrOf(input logic [3:0] c);
    case (c)
      4'h0: thrOf = 10'd300;
      4'h1: thrOf = 10'd250;
      4'h2: thrOf = 10'd225;
      4'h3: thrOf = 10'd200;
      4'h4: thrOf = 10'd175;
      4'h5: thrOf = 10'd150;
      4'h6: thrOf = 10'd125;
      4'h7: thrOf = 10'd100;
      default: thrOf = 10'(10'd90 - 10'(({6'h0, c} - 10'd8) * 10'd10));
    endcase
  endfunction

  function automatic logic [8:0] blankOf(input logic [3:0] c);
    logic [13:0] ns;
    ns = 14'd0;
    case (c)
      4'h0: ns = 14'd0;
      4'h1: ns = 14'd50;
      4'hb: ns = 14'd1000;
      4'hc: ns = 14'd2000;
      4'hd: ns = 14'd4000;
      4'he: ns = 14'd6000;
      4'hf: ns = 14'd8000;
      default: ns = 14'(({10'h0, c} - 14'd1) * 14'd100);
    endcase
    blankOf = 9'(ns / 14'(`CSOC_CLK_PERIOD_NS));
  endfunction

  function automatic logic [8:0] deglOf(input logic [1:0] c);
    case (c)
      2'h0: deglOf = 9'd0;
      2'h1: deglOf = 9'(`CSOC_DEGL_US_1 * 1000 / `CSOC_CLK_PERIOD_NS);
      2'h2: deglOf = 9'(`CSOC_DEGL_US_2 * 1000 / `CSOC_CLK_PERIOD_NS);
      default: deglOf = 9'(`CSOC_DEGL_US_3 * 1000 / `CSOC_CLK_PERIOD_NS);
    endcase
  endfunction

  // ==========================================================
  // registers
  // ==========================================================
  logic [15:0] cfg_q;
  logic [15:0] cfgExt_q;
  logic [3:0] uid_q;
  logic otpGo_q;
  logic ocpFault_q;
  logic [15:0] rdData_q;

  wire wrCfg = regWrite && (regAddr == `CSOC_OFS_CFG);
  wire wrExt = regWrite && (regAddr == `CSOC_OFS_CFG_EXT);
  wire wrOtp = regWrite && (regAddr == `CSOC_OFS_OTP);
  wire wrStat = regWrite && (regAddr == `CSOC_OFS_STATUS);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_q <= `CSOC_RST_CFG;
      cfgExt_q <= `CSOC_RST_CFG_EXT;
    end
    else
    begin
      if (wrCfg)
        cfg_q <= regWrData;
      if (wrExt)
        cfgExt_q <= regWrData;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      uid_q <= 4'h0;
      otpGo_q <= 1'b0;
    end
    else
    begin
      otpGo_q <= wrOtp && regWrData[`CSOC_OTPGO_BIT];
      if (wrOtp)
        uid_q <= regWrData[`CSOC_UID_MSB:`CSOC_UID_LSB];
    end
  end

  // program bit is write-only and upper bits are zero on read
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      rdData_q <= 16'h0000;
    else if (regRead)
    begin
      case (regAddr)
        `CSOC_OFS_CFG: rdData_q <= cfg_q;
        `CSOC_OFS_CFG_EXT: rdData_q <= cfgExt_q;
        `CSOC_OFS_OTP: rdData_q <= {11'h000, uid_q, 1'b0};
        `CSOC_OFS_STATUS: rdData_q <= {15'h0000, ocpFault_q};
        default: rdData_q <= 16'h0000;
      endcase
    end
    else
      rdData_q <= 16'h0000;
  end

  // ==========================================================
  // field views
  // ==========================================================
  wire [1:0] deglCode = cfg_q[`CSOC_DEGL_MSB:`CSOC_DEGL_LSB];
  wire [1:0] trigCode = cfg_q[`CSOC_TRIG_MSB:`CSOC_TRIG_LSB];
  wire truncDis = cfgExt_q[`CSOC_TRUNCDIS_BIT];
  wire negDis = cfgExt_q[`CSOC_NEGDIS_BIT];
  // brake forces latching on top of the latch choice
  wire latchOn = cfgExt_q[`CSOC_LATCH_BIT] | cfgExt_q[`CSOC_BRAKE_BIT];
  wire [2:0] ampEn = cfg_q[`CSOC_AMPEN_MSB:`CSOC_AMPEN_LSB];
  // deglitch is bypassed while truncation is allowed
  wire [8:0] deglLen = truncDis ? deglOf(deglCode) : 9'd0;

  // ==========================================================
  // per-phase qualification and deglitch
  // ==========================================================
  logic [2:0] hitNow;
  logic [2:0] hitQual;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++)
    begin : g_phase
      logic [8:0] stable_q;
      // negative hits are dropped entirely when disabled
      assign hitNow[ph] = ampEn[ph] & (ocpPosHit[ph] | (ocpNegHit[ph] & ~negDis));

      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          stable_q <= 9'd0;
        else if (!hitNow[ph])
          stable_q <= 9'd0;
        else if (stable_q != 9'h1ff)
          stable_q <= 9'(stable_q + 9'd1);
      end

      assign hitQual[ph] = hitNow[ph] && (stable_q >= deglLen);
    end
  endgenerate

  // ==========================================================
  // event counting and fault
  // ==========================================================
  logic anyQual_q;
  logic [1:0] trigPrev_q;
  logic [4:0] evCount_q;
  logic [4:0] evCount_d;
  logic faultSet;
  logic faultClr;

  wire anyQual = |hitQual;
  wire qualEvent = anyQual && !anyQual_q;

  always_comb
  begin
    evCount_d = evCount_q;
    faultSet = 1'b0;
    if (qualEvent)
      evCount_d = 5'(evCount_q + 5'd1);
    case (csoc_trig_t'(trigCode))
      CSOC_TRIG_COUNT8: faultSet = qualEvent && (evCount_d >= `CSOC_COUNT_8);
      CSOC_TRIG_COUNT16: faultSet = qualEvent && (evCount_d >= `CSOC_COUNT_16);
      CSOC_TRIG_EVERY: faultSet = qualEvent && (evCount_d >= `CSOC_COUNT_1);
      default: faultSet = 1'b0;
    endcase
    // latched faults wait for software, unlatched ones follow the condition
    if (latchOn)
      faultClr = wrStat && regWrData[`CSOC_STAT_CLR_BIT];
    else
      faultClr = !anyQual;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      anyQual_q <= 1'b0;
      trigPrev_q <= 2'(`CSOC_RST_CFG >> `CSOC_TRIG_LSB);
    end
    else
    begin
      anyQual_q <= anyQual;
      trigPrev_q <= trigCode;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      evCount_q <= 5'd0;
    else if (faultSet || (faultClr && ocpFault_q) || (trigCode != trigPrev_q))
      evCount_q <= 5'd0;
    else
      evCount_q <= evCount_d;
  end

  // set wins over clear in the same cycle
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      ocpFault_q <= 1'b0;
    else if (faultSet)
      ocpFault_q <= 1'b1;
    else if (faultClr)
      ocpFault_q <= 1'b0;
  end

  // ==========================================================
  // outputs
  // ==========================================================
  logic [2:0] trunc_q;
  logic brake_q;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      trunc_q <= 3'h0;
      brake_q <= 1'b0;
    end
    else
    begin
      // truncation is independent of the trigger field and its count
      trunc_q <= truncDis ? 3'h0 : hitQual;
      brake_q <= cfgExt_q[`CSOC_BRAKE_BIT] && (ocpFault_q || faultSet);
    end
  end

  assign regRdData = rdData_q;
  assign ampEnable = ampEn;
  assign gainFromPin = cfg_q[`CSOC_GAINPIN_BIT];
  assign gainCode = cfg_q[`CSOC_GAIN_MSB:`CSOC_GAIN_LSB];
  assign gainVv = gainOf(gainCode);
  assign blankCycles = blankOf(cfg_q[`CSOC_BLANK_MSB:`CSOC_BLANK_LSB]);
  assign dcCalActive = cfg_q[`CSOC_DCCAL_BIT];
  assign powerStageHiZ = cfg_q[`CSOC_DCCAL_BIT];
  assign posThresholdCode = cfgExt_q[`CSOC_PTHR_MSB:`CSOC_PTHR_LSB];
  assign posThresholdMv = thrOf(posThresholdCode);
  assign negThresholdCode = cfgExt_q[`CSOC_NTHR_MSB:`CSOC_NTHR_LSB];
  assign negThresholdMagMv = thrOf(negThresholdCode);
  assign rdsonSensing = cfgExt_q[`CSOC_MODE_BIT];
  assign sampleLowGateOnly = cfgExt_q[`CSOC_MODE_BIT];
  assign refExternal = cfgExt_q[`CSOC_REFSEL_BIT];
  assign autozeroMode = cfgExt_q[`CSOC_AZ_MSB:`CSOC_AZ_LSB];
  assign pwmTruncate = trunc_q;
  assign ocpFault = ocpFault_q;
  assign brakeRequest = brake_q;
  assign otpProgramStart = otpGo_q;
  assign userVersionTag = uid_q;

endmodule

`default_nettype wire

/* File: csoc_config_sva.sv */
// csoc_config_sva.sv: port checks for the sense amp config block
// assumes: bound into csoc_config, one clock, async active-high reset
`default_nettype none

// ==========
// checker
module csoc_config_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic [2:0] ampEnable,
  input wire logic gainFromPin,
  input wire logic [2:0] gainCode,
  input wire logic [6:0] gainVv,
  input wire logic rdsonSensing,
  input wire logic sampleLowGateOnly,
  input wire logic [2:0] pwmTruncate,
  input wire logic otpProgramStart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence otpGo;
    regWrite && regAddr == 8'h1f && regWrData[0];
  endsequence
  sequence otpRead;
    regRead && regAddr == 8'h1f;
  endsequence

  rd_idle_a:
    assert property (!$past(regRead) |-> regRdData == 16'h0000) else $error("idle read data");
  otp_pulse_a:
    assert property (otpGo |=> otpProgramStart ##1 !otpProgramStart) else $error("no start pulse");
  otp_only_a:
    assert property (otpProgramStart |-> $past(regWrite && regAddr == 8'h1f && regWrData[0]))
      else $error("stray start pulse");
  otp_rsvd_a:
    assert property (otpRead |=> regRdData[15:5] == 11'h000 && !regRdData[0])
      else $error("program reg reserved bits set");
  gain_dec_a:
    assert property (!gainFromPin |-> gainVv == ((gainCode == 3'h7) ? 7'h40 :
      (gainCode == 3'h6) ? 7'h20 : {2'h0, gainCode, 2'h0} + 7'h04)) else $error("gain decode");
  trunc_amp_a:
    assert property ((pwmTruncate & ~$past(ampEnable)) == 3'h0) else $error("disabled amp trips");
  cfg_write_a:
    assert property (regWrite && regAddr == 8'h1d |=> ampEnable == $past(regWrData[6:4])
      && gainFromPin == $past(regWrData[3])) else $error("cfg write lost");
  ext_write_a:
    assert property (regWrite && regAddr == 8'h1e |=> rdsonSensing == $past(regWrData[9])
      && sampleLowGateOnly == rdsonSensing) else $error("sensing mode");
endmodule

bind csoc_config csoc_config_sva csoc_config_sva_inst (.*);

`default_nettype wire

/* File: csoc_host.sv */
// csoc_host.sv: host model driving the register port
// assumes: read data stands in the cycle after the read strobe
`default_nettype none

// ==========
// host
module csoc_host (
  input wire logic core_clk,
  output var logic [7:0] regAddr,
  output var logic [15:0] regWrData,
  output var logic regWrite,
  output var logic regRead,
  input wire logic [15:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // a program start is just a write with bit 0 set
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // sampled mid-cycle: the data stand for one cycle only
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    v = regRdData;
  endtask
endmodule

`default_nettype wire

/* File: csoc_config_tb.sv */
// csoc_config_tb.sv: self-checking bench of the sense amp config block
// assumes: csoc_config, csoc_host and the checker are compiled before it
`default_nettype none

`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end

// ==========
// bench
module csoc_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, regWrite, regRead, gainFromPin, dcCalActive, powerStageHiZ;
  logic rdsonSensing, sampleLowGateOnly, refExternal, ocpFault, brakeRequest, otpProgramStart;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, d;
  logic [2:0] ocpPosHit, ocpNegHit, ampEnable, gainCode, pwmTruncate;
  logic [6:0] gainVv;
  logic [8:0] blankCycles;
  logic [3:0] posThresholdCode, negThresholdCode, userVersionTag;
  logic [9:0] posThresholdMv, negThresholdMagMv;
  logic [1:0] autozeroMode;
  int err_total = 0;
  int cmp_count = 0;
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] ext;
    logic [2:0] p;
    logic [2:0] n;
    logic f;
    logic [2:0] t;
    logic late;
  } csoc_case_t;
  // cfg, ext, pos hit, neg hit, fault, truncate, fault four cycles later
  csoc_case_t cases [8] = '{
    '{16'h8070, 16'h0033, 3'h1, 3'h0, 1'b1, 3'h1, 1'b0},
    '{16'h8070, 16'h0833, 3'h1, 3'h0, 1'b1, 3'h0, 1'b0},
    '{16'h8070, 16'h0133, 3'h2, 3'h0, 1'b1, 3'h2, 1'b1},
    '{16'h8070, 16'h0433, 3'h4, 3'h0, 1'b1, 3'h4, 1'b1},
    '{16'h8070, 16'h2033, 3'h0, 3'h1, 1'b0, 3'h0, 1'b0},
    '{16'h8070, 16'h0033, 3'h0, 3'h2, 1'b1, 3'h2, 1'b0},
    '{16'h8000, 16'h0033, 3'h7, 3'h0, 1'b0, 3'h0, 1'b0},
    '{16'hc070, 16'h0033, 3'h1, 3'h0, 1'b0, 3'h1, 1'b0}
  };
  logic [7:0] ra [5] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h30};
  logic [15:0] rv [5] = '{16'h0028, 16'h0833, 16'h0000, 16'h0000, 16'h0000};

  csoc_config csoc_config_inst (.*);
  csoc_host csoc_host_inst (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic hit(input logic [2:0] p, input logic [2:0] n);
    @(posedge core_clk);
    ocpPosHit <= p;
    ocpNegHit <= n;
    @(posedge core_clk);
    ocpPosHit <= 3'h0;
    ocpNegHit <= 3'h0;
    @(negedge core_clk);
  endtask

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // tests
  initial
  begin
    reset = 1'b1;
    ocpPosHit = 3'h0;
    ocpNegHit = 3'h0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    foreach (ra[i])
    begin
      csoc_host_inst.rd(ra[i], d);
      `CHK("reset read", rv[i], d);
    end
    csoc_host_inst.wr(8'h1f, 16'h001f);
    @(negedge core_clk);
    `CHK("program start", 1'b1, otpProgramStart);
    `CHK("user tag", 4'hf, userVersionTag);
    csoc_host_inst.rd(8'h1f, d);
    `CHK("program reg", 16'h001e, d);
    csoc_host_inst.wr(8'h1d, 16'h8877);
    csoc_host_inst.wr(8'h1e, 16'h9233);
    @(negedge core_clk);
    `CHK("gain", 7'h40, gainVv);
    `CHK("amp enable", 3'h7, ampEnable);
    `CHK("calibrate", 2'b11, {dcCalActive, powerStageHiZ});
    `CHK("autozero", 2'h2, autozeroMode);
    `CHK("ref and mode", 3'h7, {refExternal, rdsonSensing, sampleLowGateOnly});
    `CHK("pos thr", 10'd200, posThresholdMv);
    `CHK("neg thr", 10'd200, negThresholdMagMv);
    csoc_host_inst.wr(8'h1d, 16'h0780);
    @(negedge core_clk);
    `CHK("blanking", 9'd320, blankCycles);
    csoc_host_inst.wr(8'h1d, 16'h807e);
    csoc_host_inst.rd(8'h1d, d);
    `CHK("cfg read", 16'h807e, d);
    `CHK("gain pin", 1'b1, gainFromPin);
    csoc_host_inst.wr(8'h1e, 16'h0033);
    // counts 8 then 16: one short of the count must stay quiet
    for (int k = 0; k < 2; k++)
    begin
      csoc_host_inst.wr(8'h1d, (k == 0) ? 16'h0070 : 16'h4070);
      repeat ((8 << k) - 1) hit(3'h1, 3'h0);
      `CHK("short count", 1'b0, ocpFault);
      hit(3'h1, 3'h0);
      `CHK("count fault", 1'b1, ocpFault);
      repeat (4) @(negedge core_clk);
    end
    // 2 us deglitch: qualifies on the 81st sampled hit cycle
    csoc_host_inst.wr(8'h1d, 16'h9070);
    csoc_host_inst.wr(8'h1e, 16'h0833);
    @(posedge core_clk);
    ocpPosHit <= 3'h1;
    repeat (80) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("deglitch early", 1'b0, ocpFault);
    @(negedge core_clk);
    `CHK("deglitch done", 1'b1, ocpFault);
    @(posedge core_clk);
    ocpPosHit <= 3'h0;
    repeat (4) @(negedge core_clk);
    foreach (cases[i])
    begin
      csoc_host_inst.wr(8'h1d, cases[i].cfg);
      csoc_host_inst.wr(8'h1e, cases[i].ext);
      hit(cases[i].p, cases[i].n);
      `CHK("fault", cases[i].f, ocpFault);
      `CHK("truncate", cases[i].t, pwmTruncate);
      repeat (4) @(negedge core_clk);
      `CHK("held fault", cases[i].late, ocpFault);
      `CHK("brake", cases[i].late & cases[i].ext[10], brakeRequest);
      csoc_host_inst.wr(8'h20, 16'h0001);
      @(negedge core_clk);
      `CHK("cleared", 1'b0, ocpFault);
    end
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end
endmodule

`default_nettype wire
